/* bench/board_model.sv */
// Board circuitry at the port pins.
// Assumes enables from the block; pull_low is the board pulling a line down.
module board_model (
  input logic clk,
  input logic [3:0] oe,
  input logic [3:0] pu,
  input logic [3:0] pull_low,
  input logic [3:0] p1_drv,
  output logic [3:0] p3_pin,
  output logic [3:0] p1_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] last_q;
  assign p1_pin = p1_drv;
  assign p3_pin = ~(oe | pull_low) & (pu | ~last_q);
  always @(posedge clk) last_q <= p3_pin;
endmodule

/* bench/port_pin_asserts.sv */
// Checker on the port pin block's top-level ports.
// Assumes one clock and a synchronous active-low reset.
module port_pin_checker #(
  parameter P3_LINES = 4,
  parameter RESET_QUAL = 24
) (
  input wire clk,
  input wire resetn,
  input wire [P3_LINES-1:0] quasi_bidir_in,
  input wire [P3_LINES-1:0] quasi_bidir_out,
  input wire [P3_LINES-1:0] quasi_bidir_oe,
  input wire [P3_LINES-1:0] strong_pu_en,
  input wire [P3_LINES-1:0] weak_pu_en,
  input wire reset_pin,
  input wire core_reset,
  input wire spi_ss_pu_en,
  input wire spi_miso_pu_en,
  input wire ext_irq_zero_req,
  input wire ext_irq_one_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] hi_q;
  // Consecutive high samples of the reset pin
  always @(posedge clk) begin
    if (!resetn || !reset_pin) hi_q <= 8'h00;
    else if (hi_q != 8'hFF) hi_q <= hi_q + 8'h01;
  end
  sequence strong_two;
    strong_pu_en[0] [*2] ##1 !strong_pu_en[0];
  endsequence
  AST_STRONG_TWO: assert property ($rose(strong_pu_en[0]) |-> strong_two)
    else $error("strong pull-up not two cycles");
  AST_WEAK_ONLY: assert property (((quasi_bidir_oe & weak_pu_en) == '0) && (quasi_bidir_out == '0))
    else $error("port 3 line driven high or pull-up fights driver");
  AST_SPI_PU: assert property (spi_ss_pu_en && spi_miso_pu_en)
    else $error("spi pull-up off");
  AST_WAKE_PU: assert property ($rose(resetn) |-> (weak_pu_en == '1) && (quasi_bidir_oe == '0))
    else $error("port 3 not pulled-up input after reset");
  AST_RST_QUAL: assert property ($rose(core_reset) |-> hi_q >= RESET_QUAL)
    else $error("reset issued after short pulse");
  AST_RST_FIRE: assert property (hi_q == RESET_QUAL + 2 |-> core_reset)
    else $error("reset not issued after qualified pulse");
  AST_RST_DROP: assert property (!reset_pin |=> !core_reset)
    else $error("reset held after pin low");
  AST_IRQ0_CAUSE: assert property (ext_irq_zero_req |->
    !$past(quasi_bidir_in[2]) || !$past(quasi_bidir_in[2], 2))
    else $error("interrupt zero without low pin");
  AST_IRQ1_CAUSE: assert property (ext_irq_one_req |->
    !$past(quasi_bidir_in[3]) || !$past(quasi_bidir_in[3], 2))
    else $error("interrupt one without low pin");
endmodule
bind port_pin_input_output_logic port_pin_checker #(.P3_LINES(P3_LINES), .RESET_QUAL(RESET_QUAL))
  i_port_pin_checker (.clk, .resetn, .quasi_bidir_in, .quasi_bidir_out, .quasi_bidir_oe,
  .strong_pu_en, .weak_pu_en, .reset_pin, .core_reset, .spi_ss_pu_en, .spi_miso_pu_en,
  .ext_irq_zero_req, .ext_irq_one_req);

/* bench/tb_port_pin_input_output_logic.sv */
// Self-checking bench for the port pin block.
// Assumes the board model at the pins and an Avalon-MM master here.
module tb_port_pin_input_output_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, rd, wr, rpin, sync, txd, sclk, sdo, sdoe, wreq, crst, ssp, misop, rxd;
  logic i0, pr0, i1, pr1, g0, g1, irq;
  logic [7:0] addr;
  logic [31:0] wd, rdat, v;
  logic [3:0] qin, qout, qoe, spu, wpu, p1, pl, p1d;
  int errors = 0, checks_done = 0, cyc = 0, n;
  port_pin_input_output_logic i_port_pin_input_output_logic (.clk(clk), .resetn(resetn),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq), .input_only_in(p1),
    .quasi_bidir_in(qin), .quasi_bidir_out(qout), .quasi_bidir_oe(qoe), .strong_pu_en(spu),
    .weak_pu_en(wpu), .reset_pin(rpin), .core_reset(crst), .spi_ss_pu_en(ssp),
    .spi_miso_pu_en(misop), .uart_sync_mode(sync), .uart_txd(txd), .uart_sclk(sclk),
    .uart_sdata_out(sdo), .uart_sdata_oe(sdoe), .uart_rxd(rxd), .ext_irq_zero_req(i0),
    .ext_irq_zero_prio(pr0), .ext_irq_one_req(i1), .ext_irq_one_prio(pr1),
    .counter_zero_gate(g0), .counter_one_gate(g1), .irq(irq));
  board_model i_board_model (.clk(clk), .oe(qoe), .pu(wpu | spu), .pull_low(pl),
    .p1_drv(p1d), .p3_pin(qin), .p1_pin(p1));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_of_test;
    end
  end
  task ck(input [31:0] g, input [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task w(input int k);
    repeat (k) @(posedge clk);
  endtask
  task acc(input logic we, input [7:0] a, input [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= we;
    rd <= !we;
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdat;
    wr <= 0;
    rd <= 0;
  endtask
  task rc(input [7:0] a, input [31:0] m, input [31:0] e);
    acc(0, a, 0);
    ck(v & m, e);
  endtask
  initial begin
    {resetn, rd, wr, rpin, sync, sclk, sdo, sdoe, pl, addr, wd} = 0;
    txd = 1;
    p1d = 4'hF;
    w(5);
    resetn <= 1;
    rc(8'h04, 32'hF, 32'hF);
    ck({ssp, misop, wpu, qoe}, 10'h3F0);
    rc(8'h00, 32'hF, 32'hF);
    rc(8'h40, 32'hFFFFFFFF, 0);
    rc(8'h08, 32'hF, 0);
    acc(1, 8'h00, 0);
    p1d <= 4'h5;
    w(3);
    rc(8'h08, 32'hF, 32'h5);
    pl <= 4'h8;
    w(3);
    rc(8'h08, 32'hF00, 32'h700);
    ck(qoe, 0);
    pl <= 0;
    acc(1, 8'h04, 0);
    w(2);
    ck(qoe, 4'hF);
    acc(1, 8'h04, 32'hF);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += $countones(spu);
    end
    ck(n, 8);
    rc(8'h14, 32'h8, 32'h8);
    ck({irq, wpu}, 5'h0F);
    acc(1, 8'h14, 32'hF);
    acc(1, 8'h10, 32'h3);
    acc(1, 8'h18, 32'h1);
    w(2);
    ck({pr0, pr1}, 2'h2);
    pl <= 4'hC;
    n = 0;
    repeat (4) begin
      @(posedge clk);
      n += i0;
    end
    ck(n, 1);
    ck({i1, g0, g1, irq}, 4'h9);
    rc(8'h14, 32'h3, 32'h3);
    pl <= 0;
    w(4);
    acc(1, 8'h14, 32'h3);
    w(2);
    ck({i1, irq, g0, g1}, 4'h3);
    acc(1, 8'h0C, 32'h3);
    {txd, sdoe} <= 2'h1;
    w(3);
    ck(qoe, 4'h2);
    {sync, sclk} <= 2'h3;
    w(3);
    ck(qoe, 4'h1);
    sync <= 0;
    pl <= 4'h1;
    w(3);
    ck({rxd, qoe}, 5'h02);
    pl <= 0;
    rpin <= 1;
    w(23);
    rpin <= 0;
    w(2);
    ck(crst, 0);
    rpin <= 1;
    w(27);
    ck(crst, 1);
    rpin <= 0;
    w(2);
    ck(crst, 0);
    rc(8'h1C, 32'h100, 32'h100);
    rc(8'h14, 32'h4, 32'h4);
    end_of_test;
  end
endmodule

/* rtl/port_pin_defs.vh */
// Constants for the port pin logic block.
// Assumes a 32-bit Avalon-MM slave with word addressing on byte address bits.
`ifndef PORT_PIN_DEFS_VH
`define PORT_PIN_DEFS_VH
`define OFS_P1_LATCH 8'h00
`define OFS_P3_LATCH 8'h04
`define OFS_PIN_STATE 8'h08
`define OFS_ALT_CTRL 8'h0C
`define OFS_IRQ_CFG 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_RESET_STAT 8'h1C
`define RST_P1_LATCH 4'hF
`define RST_P3_LATCH 4'hF
`define RESET_QUAL_CYCLES 24
`define STRONG_PU_CYCLES 2
`define UNMAPPED_DATA 32'h00000000
`endif

/* rtl/port_pin_input_output_logic.v */
// Port pin logic: input-only port 1 lines, quasi-bidirectional port 3
// lines with alternate functions, reset qualification and SPI pull-ups.
// Assumes pins are synchronous to clk and the pad resolves wire levels.
`include "port_pin_defs.vh"

// Notes on behaviour
// - Input-only port 1 lines have no driver and read as inputs only while their latch bit is 0.
// - Reset is issued only after the reset pin is high for 24 consecutive clocks.
// - A port 3 line whose effective output level is 1 is held high by pull-ups only (weak, plus strong after a rise) and reads as input.
// - A low-to-high port 3 output turns on a strong pull-up for exactly two clocks.
// - Port 3 line 0 carries UART receive data, or bidirectional data in synchronous mode.
// - Port 3 line 1 outputs UART transmit data, or the shift clock in synchronous mode.
// - Port 3 line 2 is interrupt input zero, edge or level, two priorities, and gate zero.
// - Port 3 line 3 is interrupt input one, edge or level, two priorities, and gate one.
// - Slave select and the serial data-out line have weak pull-ups and idle high.
module port_pin_input_output_logic #(
  parameter P1_LINES = 4,
  parameter P3_LINES = 4,
  parameter RESET_QUAL = `RESET_QUAL_CYCLES
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [P1_LINES-1:0] input_only_in,
  input wire [P3_LINES-1:0] quasi_bidir_in,
  output reg [P3_LINES-1:0] quasi_bidir_out,
  output reg [P3_LINES-1:0] quasi_bidir_oe,
  output reg [P3_LINES-1:0] strong_pu_en,
  output reg [P3_LINES-1:0] weak_pu_en,
  input wire reset_pin,
  output reg core_reset,
  output reg spi_ss_pu_en,
  output reg spi_miso_pu_en,
  input wire uart_sync_mode,
  input wire uart_txd,
  input wire uart_sclk,
  input wire uart_sdata_out,
  input wire uart_sdata_oe,
  output reg uart_rxd,
  output reg ext_irq_zero_req,
  output reg ext_irq_zero_prio,
  output reg ext_irq_one_req,
  output reg ext_irq_one_prio,
  output reg counter_zero_gate,
  output reg counter_one_gate,
  output reg irq
);

  localparam PU_LOAD_INT = `STRONG_PU_CYCLES - 1;
  localparam QUAL_LAST_INT = RESET_QUAL - 1;
  localparam [1:0] PU_LOAD = PU_LOAD_INT[1:0];
  localparam [7:0] QUAL_LAST = QUAL_LAST_INT[7:0];

  // Software-visible state and bus ack flag
  reg [P1_LINES-1:0] p1_latch_q;
  reg [P3_LINES-1:0] p3_latch_q;
  reg [1:0] alt_en_q;
  reg [3:0] irq_cfg_q;
  reg [3:0] status_q;
  reg [3:0] mask_q;
  reg [7:0] qual_cnt_q;
  reg rst_seen_q;
  reg ack_q;

  // Pin-side state
  reg [P3_LINES-1:0] drive_q;
  reg [P3_LINES-1:0] prev_drive_q;
  reg [P3_LINES-1:0] pin_prev_q;

  // Next values
  reg [P3_LINES-1:0] drive_d;
  reg [3:0] ev;
  reg [3:0] status_d;
  reg [7:0] qual_cnt_d;
  reg core_reset_d;
  reg [31:0] readdata_d;
  reg irq_d;

  wire [P1_LINES-1:0] p1_read;
  wire [P3_LINES-1:0] rise;
  wire req;
  wire rd_take;
  wire wr_commit;
  wire ctrl_lane;
  wire [31:0] wmask;
  genvar gi;

  // Bus: a request is seen while ack is low and answered one cycle later
  assign req = (avs_read | avs_write) & ~ack_q;
  assign rd_take = avs_read & ~ack_q;
  // Writes land on the edge where the master sees waitrequest low
  assign wr_commit = avs_write & ack_q;
  assign ctrl_lane = avs_byteenable[0];
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  assign p1_read = input_only_in & ~p1_latch_q;

  assign rise = drive_q & ~prev_drive_q;

  // Effective output level: alternate function output ANDed with latch
  always @* begin
    drive_d = p3_latch_q;
    if (alt_en_q[0] && uart_sync_mode && uart_sdata_oe) begin
      drive_d[0] = p3_latch_q[0] & uart_sdata_out;
    end
    if (alt_en_q[1]) begin
      drive_d[1] = p3_latch_q[1] & (uart_sync_mode ? uart_sclk : uart_txd);
    end
  end

  // Interrupt events: edge mode falling edge, level mode low level
  always @* begin
    ev = 4'h0;
    if (irq_cfg_q[0]) begin
      ev[0] = pin_prev_q[2] & ~quasi_bidir_in[2];
    end else begin
      ev[0] = ~quasi_bidir_in[2];
    end
    if (irq_cfg_q[2]) begin
      ev[1] = pin_prev_q[3] & ~quasi_bidir_in[3];
    end else begin
      ev[1] = ~quasi_bidir_in[3];
    end
    ev[2] = core_reset;
    ev[3] = |rise;
  end

  // Sticky status: set wins over write-one-clear
  always @* begin
    status_d = status_q | ev;
    if (wr_commit && ctrl_lane && avs_address == `OFS_IRQ_STATUS) begin
      status_d = (status_q & ~avs_writedata[3:0]) | ev;
    end
    irq_d = |(status_q & mask_q);
  end

  always @* begin
    qual_cnt_d = qual_cnt_q;
    core_reset_d = core_reset;
    if (!reset_pin) begin
      qual_cnt_d = 8'h00;
      core_reset_d = 1'b0;
    end else if (qual_cnt_q >= QUAL_LAST) begin
      core_reset_d = 1'b1;
    end else begin
      qual_cnt_d = qual_cnt_q + 8'h01;
    end
  end

  // Read multiplexer
  always @* begin
    if (avs_address == `OFS_P1_LATCH) begin
      readdata_d = {{(32-P1_LINES){1'b0}}, p1_latch_q};
    end else if (avs_address == `OFS_P3_LATCH) begin
      readdata_d = {{(32-P3_LINES){1'b0}}, p3_latch_q};
    end else if (avs_address == `OFS_PIN_STATE) begin
      readdata_d = {{(24-P3_LINES){1'b0}}, quasi_bidir_in, {(8-P1_LINES){1'b0}}, p1_read};
    end else if (avs_address == `OFS_ALT_CTRL) begin
      readdata_d = {30'h00000000, alt_en_q};
    end else if (avs_address == `OFS_IRQ_CFG) begin
      readdata_d = {28'h0000000, irq_cfg_q};
    end else if (avs_address == `OFS_IRQ_STATUS) begin
      readdata_d = {28'h0000000, status_q};
    end else if (avs_address == `OFS_IRQ_MASK) begin
      readdata_d = {28'h0000000, mask_q};
    end else if (avs_address == `OFS_RESET_STAT) begin
      readdata_d = {23'h000000, rst_seen_q, qual_cnt_q};
    end else begin
      readdata_d = `UNMAPPED_DATA;
    end
  end

  // Bus slave: one wait cycle, then answer
  always @(posedge clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= req;
      avs_waitrequest <= ~req;
      if (rd_take) begin
        avs_readdata <= readdata_d;
      end
    end
  end

  // Software registers
  always @(posedge clk) begin
    if (!resetn) begin
      p1_latch_q <= `RST_P1_LATCH;
      p3_latch_q <= `RST_P3_LATCH;
      alt_en_q <= 2'h0;
      irq_cfg_q <= 4'h0;
      mask_q <= 4'h0;
    end else if (wr_commit) begin
      if (avs_address == `OFS_P1_LATCH) begin
        p1_latch_q <= (p1_latch_q & ~wmask[P1_LINES-1:0]) |
                      (avs_writedata[P1_LINES-1:0] & wmask[P1_LINES-1:0]);
      end else if (avs_address == `OFS_P3_LATCH) begin
        p3_latch_q <= (p3_latch_q & ~wmask[P3_LINES-1:0]) |
                      (avs_writedata[P3_LINES-1:0] & wmask[P3_LINES-1:0]);
      end else if (avs_address == `OFS_ALT_CTRL && ctrl_lane) begin
        alt_en_q <= avs_writedata[1:0];
      end else if (avs_address == `OFS_IRQ_CFG && ctrl_lane) begin
        irq_cfg_q <= avs_writedata[3:0];
      end else if (avs_address == `OFS_IRQ_MASK && ctrl_lane) begin
        mask_q <= avs_writedata[3:0];
      end
    end
  end

  // Status and interrupt output
  always @(posedge clk) begin
    if (!resetn) begin
      status_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      status_q <= status_d;
      irq <= irq_d;
    end
  end

  // Reset qualification state
  always @(posedge clk) begin
    if (!resetn) begin
      qual_cnt_q <= 8'h00;
      core_reset <= 1'b0;
      rst_seen_q <= 1'b0;
    end else begin
      qual_cnt_q <= qual_cnt_d;
      core_reset <= core_reset_d;
      if (core_reset) begin
        rst_seen_q <= 1'b1;
      end
    end
  end

  // Per-line port 3 drivers and pull-ups
  generate
    for (gi = 0; gi < P3_LINES; gi = gi + 1) begin : g_line
      reg [1:0] pu_cnt_q;
      // Level history for output rise and input edge detection
      always @(posedge clk) begin
        if (!resetn) begin
          drive_q[gi] <= 1'b1;
          prev_drive_q[gi] <= 1'b1;
          pin_prev_q[gi] <= 1'b1;
        end else begin
          drive_q[gi] <= drive_d[gi];
          prev_drive_q[gi] <= drive_q[gi];
          pin_prev_q[gi] <= quasi_bidir_in[gi];
        end
      end
      always @(posedge clk) begin
        if (!resetn) begin
          quasi_bidir_out[gi] <= 1'b0;
          quasi_bidir_oe[gi] <= 1'b0;
          weak_pu_en[gi] <= 1'b1;
        end else begin
          quasi_bidir_out[gi] <= 1'b0;
          quasi_bidir_oe[gi] <= ~drive_d[gi];
          weak_pu_en[gi] <= drive_d[gi];
        end
      end
      always @(posedge clk) begin
        if (!resetn) begin
          pu_cnt_q <= 2'h0;
          strong_pu_en[gi] <= 1'b0;
        end else if (rise[gi]) begin
          pu_cnt_q <= PU_LOAD;
          strong_pu_en[gi] <= 1'b1;
        end else if (pu_cnt_q != 2'h0) begin
          pu_cnt_q <= pu_cnt_q - 2'h1;
          strong_pu_en[gi] <= 1'b1;
        end else begin
          strong_pu_en[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!resetn) begin
      spi_ss_pu_en <= 1'b1;
      spi_miso_pu_en <= 1'b1;
    end else begin
      spi_ss_pu_en <= 1'b1;
      spi_miso_pu_en <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      uart_rxd <= 1'b1;
    end else begin
      uart_rxd <= quasi_bidir_in[0];
    end
  end

  // Interrupt requests, priorities and counter gates
  always @(posedge clk) begin
    if (!resetn) begin
      ext_irq_zero_req <= 1'b0;
      ext_irq_zero_prio <= 1'b0;
      counter_zero_gate <= 1'b0;
      ext_irq_one_req <= 1'b0;
      ext_irq_one_prio <= 1'b0;
      counter_one_gate <= 1'b0;
    end else begin
      ext_irq_zero_req <= ev[0];
      ext_irq_zero_prio <= irq_cfg_q[1];
      counter_zero_gate <= quasi_bidir_in[2];
      ext_irq_one_req <= ev[1];
      ext_irq_one_prio <= irq_cfg_q[3];
      counter_one_gate <= quasi_bidir_in[3];
    end
  end

endmodule
